// ==== hdl/psu_pkg.sv ====
// package of the parameter safeload unit: register indices, field layout, timing, types
// assumes a 40 MHz core clock and a 28-bit parameter word
package psu_pkg;

  // ************************************************************
  // widths and memory
  // ************************************************************
  localparam int             DW           = 28;
  localparam int             AXI_AW       = 8;
  localparam int             PM_DEPTH     = 16;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [4:0]     IDX_CIRC     = 5'h00;
  localparam logic [4:0]     IDX_STAGE1   = 5'h01;
  localparam logic [4:0]     IDX_STAGE5   = 5'h05;
  localparam logic [4:0]     IDX_DEST     = 5'h06;
  localparam logic [4:0]     IDX_COUNT    = 5'h07;
  localparam logic [4:0]     IDX_SLEW_TGT = 5'h08;
  localparam logic [4:0]     IDX_STATUS   = 5'h10;
  localparam logic [4:0]     IDX_BOOT     = 5'h11;
  localparam logic [4:0]     IDX_SLEW_CUR = 5'h12;

  // ************************************************************
  // status fields and reset values
  // ************************************************************
  localparam int             ST_PENDING   = 0;
  localparam int             ST_BUSY      = 1;
  localparam int             ST_OVERRUN   = 2;
  localparam logic [DW-1:0]  PM_RESET     = 28'h0000000;
  localparam logic [2:0]     STAGE_SLOTS  = 3'h5;
  localparam logic [5:0]     BOOT_WORDS   = 6'h24;

  // ************************************************************
  // bus answers
  // ************************************************************
  localparam logic [1:0]     RESP_OKAY    = 2'h0;
  localparam logic [1:0]     RESP_SLVERR  = 2'h2;

  // ************************************************************
  // timing
  // ************************************************************
  localparam real            CLK_MHZ          = 40.0;
  localparam real            SAMPLE_PERIOD_US = 20.83;
  localparam int             TRIG_GAP_CYC     = int'($ceil(SAMPLE_PERIOD_US * CLK_MHZ));
  localparam logic [9:0]     TRIG_GAP_LOAD    = 10'(TRIG_GAP_CYC - 1);

  // ************************************************************
  // slew
  // ************************************************************
  localparam logic [DW-1:0]  SLEW_LIN_STEP = 28'h0001000;
  localparam int             SLEW_RC_SHIFT = 3;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic {SLEW_RC, SLEW_LINEAR} psu_slew_curve_t;
  typedef enum logic {ST_IDLE, ST_XFER}     psu_state_t;

  typedef struct packed {
    logic          en;
    logic [3:0]    addr;
    logic [DW-1:0] data;
  } psu_pm_wr_t;

endpackage

// ==== hdl/psu_safeload.sv ====
// parameter safeload unit with axi4-lite register access and one slew channel
// assumes frame_sync_i pulses for one cycle at each audio frame boundary
`timescale 1ns/1ps
// Function
// - words one to five stage new coefficients awaiting a clean transfer
// - word six holds destination minus one, one added before the first slot
// - each further staged word lands one address higher than the last
// - writing word seven sets count and arms a transfer for next frame
// - pending transfer is checked and run at most once per audio frame
// - word zero holds the circular data memory size
// - transfer and startup code fill the first 36 instruction words
// - slewed values step each frame toward the target until equal
// - slew target is a parameter word; current value kept apart
// - slew curves are fixed: rc-like exponential or linear ramp
module psu_safeload (
  // clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        reset_n_i,
  // write address channel
  input  wire logic                        awvalid_i,
  output logic                             awready_o,
  input  wire logic [psu_pkg::AXI_AW-1:0]  awaddr_i,
  // write data channel
  input  wire logic                        wvalid_i,
  output logic                             wready_o,
  input  wire logic [31:0]                 wdata_i,
  input  wire logic [3:0]                  wstrb_i,
  // write response channel
  output logic                             bvalid_o,
  input  wire logic                        bready_i,
  output logic      [1:0]                  bresp_o,
  // read address channel
  input  wire logic                        arvalid_i,
  output logic                             arready_o,
  input  wire logic [psu_pkg::AXI_AW-1:0]  araddr_i,
  // read data channel
  output logic                             rvalid_o,
  input  wire logic                        rready_i,
  output logic      [31:0]                 rdata_o,
  output logic      [1:0]                  rresp_o,
  // audio frame timing
  input  wire logic                        frame_sync_i,
  // core outputs
  output logic      [psu_pkg::DW-1:0]      circ_size_o,
  output logic      [psu_pkg::DW-1:0]      slew_value_o,
  output logic                             xfer_busy_o
);

  logic [psu_pkg::DW-1:0] pm_r [psu_pkg::PM_DEPTH];
  logic                   aw_held_r;
  logic                   w_held_r;
  logic [4:0]             aw_idx_r;
  logic                   aw_bad_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   pending_r;
  logic                   overrun_r;
  logic [9:0]             gap_r;
  logic [2:0]             cnt_r;
  logic [2:0]             idx_r;
  logic [3:0]             dest_r;
  psu_pkg::psu_state_t    state_r;
  psu_pkg::psu_pm_wr_t    xfer_wr;
  logic                   do_wr;
  logic                   host_pm_wr;
  logic                   trig;
  logic                   start;
  logic                   cnt_nz;
  logic [2:0]             cnt_clamp;
  logic [psu_pkg::DW-1:0] wmask;
  logic [4:0]             ar_idx;
  logic                   ar_bad;
  logic [31:0]            rd_mux;

  // ************************************************************
  // write channels
  // ************************************************************
  assign do_wr      = aw_held_r && w_held_r && !bvalid_o && state_r == psu_pkg::ST_IDLE;
  assign host_pm_wr = do_wr && !aw_bad_r && aw_idx_r[4] == 1'b0;
  assign trig       = do_wr && !aw_bad_r && aw_idx_r == psu_pkg::IDX_COUNT;
  assign wmask      = {{4{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held_r <= 1'b0;
      awready_o <= 1'b1;
      aw_idx_r  <= 5'h00;
      aw_bad_r  <= 1'b0;
    end else if (awvalid_i && awready_o) begin
      aw_held_r <= 1'b1;
      awready_o <= 1'b0;
      aw_idx_r  <= awaddr_i[6:2];
      aw_bad_r  <= awaddr_i[7];
    end else if (do_wr) begin
      aw_held_r <= 1'b0;
    end else if (bvalid_o && bready_i) begin
      awready_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w_held_r <= 1'b0;
      wready_o <= 1'b1;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
    end else if (wvalid_i && wready_o) begin
      w_held_r <= 1'b1;
      wready_o <= 1'b0;
      wdata_r  <= wdata_i;
      wstrb_r  <= wstrb_i;
    end else if (do_wr) begin
      w_held_r <= 1'b0;
    end else if (bvalid_o && bready_i) begin
      wready_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= psu_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_o <= 1'b1;
      if (aw_bad_r || (aw_idx_r[4] && aw_idx_r != psu_pkg::IDX_STATUS &&
                       aw_idx_r != psu_pkg::IDX_BOOT && aw_idx_r != psu_pkg::IDX_SLEW_CUR)) begin
        bresp_o <= psu_pkg::RESP_SLVERR;
      end else begin
        bresp_o <= psu_pkg::RESP_OKAY;
      end
    end else if (bvalid_o && bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  // ************************************************************
  // parameter memory
  // ************************************************************
  generate
    for (genvar i = 0; i < psu_pkg::PM_DEPTH; i++) begin : g_pm
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          pm_r[i] <= psu_pkg::PM_RESET;
        end else if (host_pm_wr && aw_idx_r[3:0] == 4'(i)) begin
          pm_r[i] <= (pm_r[i] & ~wmask) | (wdata_r[psu_pkg::DW-1:0] & wmask);
        end else if (xfer_wr.en && xfer_wr.addr == 4'(i)) begin
          pm_r[i] <= xfer_wr.data;
        end
      end
    end
  endgenerate

  assign circ_size_o = pm_r[psu_pkg::IDX_CIRC[3:0]];

  // ************************************************************
  // safeload sequencer
  // ************************************************************
  assign cnt_nz    = |pm_r[psu_pkg::IDX_COUNT[3:0]];
  assign cnt_clamp = (pm_r[psu_pkg::IDX_COUNT[3:0]] > 28'(psu_pkg::STAGE_SLOTS)) ?
                     psu_pkg::STAGE_SLOTS : pm_r[psu_pkg::IDX_COUNT[3:0]][2:0];
  assign start     = frame_sync_i && pending_r && state_r == psu_pkg::ST_IDLE;

  always_comb begin
    xfer_wr.en   = state_r == psu_pkg::ST_XFER;
    xfer_wr.addr = dest_r + 4'(idx_r);
    xfer_wr.data = pm_r[4'(idx_r) + psu_pkg::IDX_STAGE1[3:0]];
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pending_r <= 1'b0;
    end else if (trig) begin
      pending_r <= 1'b1;
    end else if (start) begin
      pending_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r     <= psu_pkg::ST_IDLE;
      xfer_busy_o <= 1'b0;
      cnt_r       <= 3'h0;
      idx_r       <= 3'h0;
      dest_r      <= 4'h0;
    end else begin
      case (state_r)
        psu_pkg::ST_IDLE: begin
          if (start && cnt_nz) begin
            state_r     <= psu_pkg::ST_XFER;
            xfer_busy_o <= 1'b1;
            cnt_r       <= cnt_clamp;
            idx_r       <= 3'h0;
            dest_r      <= pm_r[psu_pkg::IDX_DEST[3:0]][3:0] + psu_pkg::IDX_STAGE1[3:0];
          end
        end
        psu_pkg::ST_XFER: begin
          if (idx_r == cnt_r - 3'h1) begin
            state_r     <= psu_pkg::ST_IDLE;
            xfer_busy_o <= 1'b0;
          end else begin
            idx_r <= idx_r + 3'h1;
          end
        end
        default: begin
          state_r     <= psu_pkg::ST_IDLE;
          xfer_busy_o <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // trigger spacing watch
  // ************************************************************
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap_r <= 10'h000;
    end else if (trig) begin
      gap_r <= psu_pkg::TRIG_GAP_LOAD;
    end else if (gap_r != 10'h000) begin
      gap_r <= gap_r - 10'h001;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overrun_r <= 1'b0;
    end else if (trig && gap_r != 10'h000) begin
      overrun_r <= 1'b1;
    end else if (do_wr && !aw_bad_r && aw_idx_r == psu_pkg::IDX_STATUS &&
                 wstrb_r[0] && wdata_r[psu_pkg::ST_OVERRUN]) begin
      overrun_r <= 1'b0;
    end
  end

  // ************************************************************
  // read channels
  // ************************************************************
  assign ar_idx = araddr_i[6:2];
  assign ar_bad = araddr_i[7];

  always_comb begin
    rd_mux = 32'h00000000;
    if (ar_bad) begin
      rd_mux = 32'h00000000;
    end else if (ar_idx[4] == 1'b0) begin
      rd_mux = {4'h0, pm_r[ar_idx[3:0]]};
    end else if (ar_idx == psu_pkg::IDX_STATUS) begin
      rd_mux[psu_pkg::ST_PENDING] = pending_r;
      rd_mux[psu_pkg::ST_BUSY]    = xfer_busy_o;
      rd_mux[psu_pkg::ST_OVERRUN] = overrun_r;
    end else if (ar_idx == psu_pkg::IDX_BOOT) begin
      rd_mux = {26'h0, psu_pkg::BOOT_WORDS};
    end else if (ar_idx == psu_pkg::IDX_SLEW_CUR) begin
      rd_mux = {4'h0, slew_value_o};
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h00000000;
      rresp_o   <= psu_pkg::RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b1;
      rdata_o   <= rd_mux;
      if (ar_bad || (ar_idx[4] && ar_idx != psu_pkg::IDX_STATUS &&
                     ar_idx != psu_pkg::IDX_BOOT && ar_idx != psu_pkg::IDX_SLEW_CUR)) begin
        rresp_o <= psu_pkg::RESP_SLVERR;
      end else begin
        rresp_o <= psu_pkg::RESP_OKAY;
      end
    end else if (rvalid_o && rready_i) begin
      rvalid_o  <= 1'b0;
      arready_o <= 1'b1;
    end
  end

  // ************************************************************
  // slew channel
  // ************************************************************
  psu_slew #(
    .CURVE     (psu_pkg::SLEW_RC)
  ) u_slew (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .frame_i   (frame_sync_i),
    .target_i  (pm_r[psu_pkg::IDX_SLEW_TGT[3:0]]),
    .value_o   (slew_value_o)
  );

  // ************************************************************
  // checks
  // ************************************************************
  sequence seq_arm;
    trig;
  endsequence

  sequence seq_go;
    start && cnt_nz;
  endsequence

  AST_TRIG_PENDS: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    seq_arm |=> pending_r)
    else $error("count write did not arm a transfer");

  AST_START_ON_FRAME: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(xfer_busy_o) |-> $past(frame_sync_i) && $past(pending_r))
    else $error("transfer began without frame and pending request");

  AST_FIRST_DEST: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    seq_go |=> xfer_wr.addr == $past(pm_r[psu_pkg::IDX_DEST[3:0]][3:0]) + 4'h1)
    else $error("first transfer address not destination plus one");

  AST_DEST_STEP: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    xfer_wr.en && $past(xfer_wr.en) |-> xfer_wr.addr == $past(xfer_wr.addr) + 4'h1)
    else $error("transfer address did not step by one");

  AST_WORD_LANDS: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    seq_go ##1 xfer_wr.en |=> pm_r[$past(xfer_wr.addr)] == pm_r[psu_pkg::IDX_STAGE1[3:0]] ||
                              $past(xfer_wr.addr) == psu_pkg::IDX_STAGE1[3:0])
    else $error("first staged word not copied");

  AST_XFER_ENDS: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    seq_go |-> ##[1:6] !xfer_busy_o)
    else $error("transfer did not finish within its frame");

  AST_OVERRUN_FLAG: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    trig && gap_r != 10'h000 |=> overrun_r [*2])
    else $error("early trigger not flagged");

  AST_CIRC_SIZE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    host_pm_wr && aw_idx_r == psu_pkg::IDX_CIRC && wstrb_r == 4'hf |=>
      circ_size_o == $past(wdata_r[psu_pkg::DW-1:0]))
    else $error("circular size word not updated");

  AST_BOOT_WORDS: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    arvalid_i && arready_o && !ar_bad && ar_idx == psu_pkg::IDX_BOOT |=>
      rdata_o == {26'h0, psu_pkg::BOOT_WORDS})
    else $error("reserved instruction word count wrong");

endmodule // psu_safeload

// ==== hdl/psu_slew.sv ====
// slew engine: moves a working value toward a target once per audio frame
// assumes frame_i is a one-cycle pulse synchronous to mclk_i
`timescale 1ns/1ps
module psu_slew #(
  parameter psu_pkg::psu_slew_curve_t CURVE = psu_pkg::SLEW_RC
) (
  // clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    reset_n_i,
  // frame and target
  input  wire logic                    frame_i,
  input  wire logic [psu_pkg::DW-1:0]  target_i,
  // working value
  output logic      [psu_pkg::DW-1:0]  value_o
);

  logic signed [psu_pkg::DW:0]   diff;
  logic        [psu_pkg::DW-1:0] mag;
  logic        [psu_pkg::DW-1:0] step;
  logic        [psu_pkg::DW-1:0] value_nxt;

  // ************************************************************
  // step along the fixed curve
  // ************************************************************
  always_comb begin
    diff = $signed({target_i[psu_pkg::DW-1], target_i}) - $signed({value_o[psu_pkg::DW-1], value_o});
    mag  = diff[psu_pkg::DW] ? psu_pkg::DW'(-diff) : diff[psu_pkg::DW-1:0];
    if (CURVE == psu_pkg::SLEW_LINEAR) begin
      step = (mag > psu_pkg::SLEW_LIN_STEP) ? psu_pkg::SLEW_LIN_STEP : mag;
    end else begin
      step = mag >> psu_pkg::SLEW_RC_SHIFT;
      if (step == '0 && mag != '0) begin
        step = 28'h0000001;
      end
    end
    value_nxt = diff[psu_pkg::DW] ? value_o - step : value_o + step;
  end

  // current value lives here, apart from the circular region
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      value_o <= psu_pkg::PM_RESET;
    end else if (frame_i) begin
      value_o <= value_nxt;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_SLEW_TOWARD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    frame_i && $signed(value_o) < $signed(target_i) && $stable(target_i) [*1] |=>
      $signed(value_o) > $signed($past(value_o)) && $signed(value_o) <= $signed(target_i))
    else $error("slew value did not move up toward target");

  AST_SLEW_HOLD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    frame_i && value_o == target_i |=> value_o == $past(target_i))
    else $error("slew value left a reached target");

  AST_SLEW_LIN: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    CURVE == psu_pkg::SLEW_LINEAR && frame_i |=>
      (value_o - $past(value_o) <= psu_pkg::SLEW_LIN_STEP) ||
      ($past(value_o) - value_o <= psu_pkg::SLEW_LIN_STEP))
    else $error("linear slew step too large");

endmodule // psu_slew

// ==== sim/psu_host_model.sv ====
// host model: axi4-lite master tasks for the safeload unit
// assumes a free-running mclk_i and a bench that calls these tasks
`timescale 1ns/1ps
module psu_host_model (
  // clock
  input  wire logic        mclk_i,
  // write side
  output logic             awvalid_o,
  output logic      [7:0]  awaddr_o,
  output logic             wvalid_o,
  output logic      [31:0] wdata_o,
  output logic      [3:0]  wstrb_o,
  output logic             bready_o,
  input  wire logic        awready_i,
  input  wire logic        wready_i,
  input  wire logic        bvalid_i,
  input  wire logic [1:0]  bresp_i,
  // read side
  output logic             arvalid_o,
  output logic      [7:0]  araddr_o,
  output logic             rready_o,
  input  wire logic        arready_i,
  input  wire logic        rvalid_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i
);
  int cyc = 0;
  int last_trig = -100000;
  initial {awvalid_o, awaddr_o, wvalid_o, wdata_o, wstrb_o, bready_o, arvalid_o, araddr_o,
           rready_o} = '0;
  always @(posedge mclk_i) cyc++;
  // ****
  // bus cycles
  // ****
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    awaddr_o  <= a;
    wdata_o   <= d;
    wstrb_o   <= 4'hf;
    bready_o  <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awready_i === 1'b1) awvalid_o <= 1'b0;
      if (wready_i === 1'b1) wvalid_o <= 1'b0;
    end while (bvalid_i !== 1'b1);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    arvalid_o <= 1'b1;
    araddr_o  <= a;
    rready_o  <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arready_i === 1'b1) arvalid_o <= 1'b0;
    end while (rvalid_i !== 1'b1);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
  task automatic set_dest(input logic [3:0] dst);
    logic [1:0] r;
    wr(8'h18, 32'(dst - 4'h1), r);
  endtask
  task automatic trig(input int n);
    logic [1:0] r;
    while (cyc - last_trig < psu_pkg::TRIG_GAP_CYC + 8) @(posedge mclk_i);
    wr(8'h1c, 32'(n), r);
    last_trig = cyc;
  endtask
endmodule // psu_host_model

// ==== sim/tb_psu_safeload.sv ====
// bench of the safeload unit: register map, staged transfers, slew
// assumes psu_pkg, the design and the host model are compiled first
`timescale 1ns/1ps
module tb_psu_safeload;
  logic                   mclk_i = 1'b0;
  logic                   reset_n_i = 1'b0;
  logic                   frame_sync_i = 1'b0;
  logic                   awvalid, awready, wvalid, wready, bvalid, bready;
  logic                   arvalid, arready, rvalid, rready, xfer_busy_o;
  logic [7:0]             awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp;
  logic [psu_pkg::DW-1:0] circ_size_o, slew_value_o;
  int                     bad_count = 0;
  int                     n_compared = 0;
  int                     seed = 10;
  int                     cycles = 0;
  always #12.5 mclk_i = ~mclk_i;
  psu_safeload dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .awvalid_i(awvalid),
    .awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid), .wready_o(wready),
    .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
    .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr), .rvalid_o(rvalid),
    .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp), .frame_sync_i(frame_sync_i),
    .circ_size_o(circ_size_o), .slew_value_o(slew_value_o), .xfer_busy_o(xfer_busy_o));
  psu_host_model host (.mclk_i(mclk_i), .awvalid_o(awvalid), .awaddr_o(awaddr),
    .wvalid_o(wvalid), .wdata_o(wdata), .wstrb_o(wstrb), .bready_o(bready),
    .awready_i(awready), .wready_i(wready), .bvalid_i(bvalid), .bresp_i(bresp),
    .arvalid_o(arvalid), .araddr_o(araddr), .rready_o(rready), .arready_i(arready),
    .rvalid_i(rvalid), .rdata_i(rdata), .rresp_i(rresp));
  // ****
  // helpers
  // ****
  task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    host.rd(a, d, r);
    chk_r(r, psu_pkg::RESP_OKAY);
    chk_d(d, exp);
  endtask
  task automatic frame();
    @(posedge mclk_i);
    frame_sync_i <= 1'b1;
    @(posedge mclk_i);
    frame_sync_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    for (int i = 0; i < 20 && xfer_busy_o === 1'b1; i++) @(posedge mclk_i);
  endtask
  function automatic logic [27:0] slew_next(logic [27:0] v, logic [27:0] t);
    logic [27:0] s;
    logic        up;
    up = $signed(t) > $signed(v);
    s = (up ? t - v : v - t) >> 3;
    if (s == 28'h0) s = (t != v) ? 28'h1 : 28'h0;
    return up ? v + s : v - s;
  endfunction
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      $display("CHECK FAILED at %0t: run too long", $time);
      finish_test();
    end
  end
  // ****
  // sequence
  // ****
  initial begin
    logic [27:0] v [1:5];
    logic [27:0] t;
    logic [27:0] cur;
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  f;
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rdchk(8'h44, 32'(psu_pkg::BOOT_WORDS));
    rdchk(8'h00, 32'h0);
    host.rd(8'h80, d, r);
    chk_r(r, psu_pkg::RESP_SLVERR);
    t = 28'($random(seed));
    host.wr(8'h00, 32'(t), r);
    chk_d(32'(circ_size_o), 32'(t));
    rdchk(8'h00, 32'(t));
    $display("test registers done");
    for (int n = 1; n <= 5; n++) begin
      f = 4'h8 + 4'($random(seed) & 3);
      for (int k = 1; k <= 5; k++) begin
        v[k] = 28'($random(seed));
        host.wr(8'(4 * k), 32'(v[k]), r);
      end
      for (int j = f; j <= 15; j++) host.wr(8'(4 * j), 32'(j), r);
      host.set_dest(f);
      host.trig(n);
      repeat (3) @(posedge mclk_i);
      rdchk(8'(4 * f), 32'(f));
      frame();
      chk_d(32'(xfer_busy_o), 32'h0);
      for (int k = 0; k < 5; k++) rdchk(8'(4 * (f + k)), (k < n) ? 32'(v[k + 1]) : 32'(f + k));
      rdchk(8'h40, 32'h0);
      host.wr(8'(4 * f), 32'h0, r);
      frame();
      rdchk(8'(4 * f), 32'h0);
    end
    host.wr(8'h1c, 32'h0, r);
    chk_r(r, psu_pkg::RESP_OKAY);
    rdchk(8'h40, (32'h1 << psu_pkg::ST_PENDING) | (32'h1 << psu_pkg::ST_OVERRUN));
    host.wr(8'h40, 32'h1 << psu_pkg::ST_OVERRUN, r);
    chk_r(r, psu_pkg::RESP_OKAY);
    rdchk(8'h40, 32'h1 << psu_pkg::ST_PENDING);
    frame();
    rdchk(8'h40, 32'h0);
    $display("test safeload done");
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    cur = 28'h0;
    t = 28'($random(seed));
    for (int p = 0; p < 2; p++) begin
      if (p == 1) t = t >> 1;
      host.wr(8'h20, 32'(t), r);
      for (int i = 0; i < 250; i++) begin
        frame();
        cur = slew_next(cur, t);
        chk_d(32'(slew_value_o), 32'(cur));
      end
      chk_d(32'(slew_value_o), 32'(t));
      rdchk(8'h48, 32'(t));
    end
    $display("test slew done");
    finish_test();
  end
endmodule // tb_psu_safeload
